// *** design/can_mode_pkg.sv ***
// Package with the register map, field positions, reset values and timing figures of the CAN mode block.
// Assumes a 40 MHz aclk; every user of these names writes the package name in full.
package can_mode_pkg;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned ADDR_W = 8;
    // Byte addresses of the 32-bit register words.
    localparam logic [7:0] OFS_MODE_CONTROL = 8'h00;
    localparam logic [7:0] OFS_BIT_TIMING_FIRST = 8'h04;
    localparam logic [7:0] OFS_REQUEST_CONTROL = 8'h08;
    localparam logic [7:0] OFS_ENGINE_STATUS = 8'h0C;
    // Mode control bit positions.
    localparam int unsigned BIT_MODULE_ENABLE = 7;
    localparam int unsigned BIT_CLOCK_SELECT = 6;
    localparam int unsigned BIT_SELFTEST_RETURN = 5;
    localparam int unsigned BIT_MONITOR_MODE = 4;
    localparam int unsigned BIT_BUSOFF_POLICY = 3;
    localparam int unsigned BIT_WAKE_FILTER = 2;
    localparam int unsigned BIT_SLEEP_ACK = 1;
    localparam int unsigned BIT_INIT_ACK = 0;
    // Request control bit positions.
    localparam int unsigned BIT_INIT_REQUEST = 0;
    localparam int unsigned BIT_SLEEP_REQUEST = 1;
    localparam int unsigned BIT_WAKE_ENABLE = 2;
    // Bit timing fields.
    localparam int unsigned JUMP_MSB = 7;
    localparam int unsigned JUMP_LSB = 6;
    localparam int unsigned PRESCALE_MSB = 5;
    localparam int unsigned PRESCALE_LSB = 0;
    // Reset values.
    localparam logic [7:0] RST_MODE_CONTROL = 8'h00;
    localparam logic [7:0] RST_BIT_TIMING = 8'h00;
    localparam logic [7:0] RST_REQUEST = 8'h01;
    // Bus answers.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    // Bus levels and resynchronisation counts.
    localparam logic RECESSIVE = 1'b1;
    localparam int unsigned IDLE_BITS = 11;
    localparam int unsigned BUSOFF_IDLE_RUNS = 128;
    // Shortest dominant pulse that wakes the block when filtering is on.
    localparam int unsigned WAKE_PULSE_MIN_TIME_NS = 1000;
    localparam int unsigned WAKE_PULSE_CYCLES = (WAKE_PULSE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_ABORT = 2'b01,
        ST_INIT = 2'b11,
        ST_SLEEP = 2'b10
    } mode_state_t;
endpackage

// *** design/quantum_divider.sv ***
// Time quantum divider: turns aclk into a one-cycle quantum tick every prescaler-value-plus-one cycles.
// Assumes the prescaler field is stable while enable is high.
`timescale 1ns/1ps
module quantum_divider #(
    parameter int unsigned PRESCALE_W = 6
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic enable,
    input wire logic [PRESCALE_W-1:0] prescale_field,
    // Output
    output logic tq_tick
);
    initial begin
        if (PRESCALE_W < 1) $error("quantum_divider needs a prescaler field");
    end

    logic [PRESCALE_W-1:0] count;
    wire at_end = (count == prescale_field);

    always_ff @(posedge aclk) begin
        if (!aresetn || !enable || at_end) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    assign tq_tick = enable && at_end;

    a_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
        (tq_tick && enable && $stable(prescale_field) && prescale_field != '0) |=> !tq_tick)
        else $error("quantum tick repeated with prescaler above one");
endmodule // quantum_divider

// *** design/wake_detector.sv ***
// Wake detector: reports dominant bus activity, either at once or after a minimum dominant pulse.
// Assumes the bus level is synchronous to aclk.
`timescale 1ns/1ps
module wake_detector #(
    parameter int unsigned PULSE_CYCLES = can_mode_pkg::WAKE_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic armed,
    input wire logic filter_on,
    input wire logic bus_level,
    // Output
    output logic wake
);
    localparam int unsigned CW = $clog2(PULSE_CYCLES + 1);
    initial begin
        if (PULSE_CYCLES < 1) $error("wake_detector needs a pulse of at least one cycle");
    end

    logic [CW-1:0] run;
    wire dominant = (bus_level != can_mode_pkg::RECESSIVE);
    wire long_enough = (run >= CW'(PULSE_CYCLES - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn || !armed || !dominant) begin
            run <= '0;
        end else if (!long_enough) begin
            run <= run + 1'b1;
        end
    end

    // A short glitch never completes the count, so it cannot wake a filtered node.
    assign wake = armed && dominant && (!filter_on || long_enough);
endmodule // wake_detector

// *** design/can_mode_control.sv ***
// Mode control and first bit timing register of a CAN controller, with an AXI4-Lite register slave.
// Assumes the protocol engine supplies the bit strobe, busy flags and bus-off state on aclk.
`timescale 1ns/1ps

module can_mode_control #(
    parameter int unsigned WAKE_CYCLES = can_mode_pkg::WAKE_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [can_mode_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [can_mode_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // System mode
    input wire logic special_mode,
    // Protocol engine side
    input wire logic bit_strobe,
    input wire logic engine_tx,
    input wire logic rx_busy,
    input wire logic tx_pending,
    input wire logic busoff,
    output logic engine_rx,
    output logic abort_traffic,
    output logic bus_synced,
    output logic tq_tick,
    output logic [2:0] jump_width_tq,
    output logic module_enable,
    output logic engine_clock_select,
    output logic busoff_recovery_policy,
    output logic ack_error_allow,
    output logic error_count_hold,
    output logic tx_start_allow,
    // Bus pins
    input wire logic bus_rx,
    output logic bus_tx
);
    initial begin
        if (WAKE_CYCLES < 1) $error("can_mode_control needs a wake pulse of at least one cycle");
    end

    can_mode_pkg::mode_state_t state;
    can_mode_pkg::mode_state_t next_state;
    logic [7:0] mode_reg;
    logic [7:0] timing_reg;
    logic init_request;
    logic sleep_request;
    logic wake_on_traffic_enable;
    logic enable_written;
    logic aw_held;
    logic w_held;
    logic [can_mode_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [3:0] idle_run;
    logic [7:0] busoff_runs;
    logic wake;

    // Handshake state.
    wire init_acknowledge = (state == can_mode_pkg::ST_INIT);
    wire sleep_acknowledge = (state == can_mode_pkg::ST_SLEEP);
    wire init_active = init_request && init_acknowledge;
    wire sleep_active = sleep_request && sleep_acknowledge;
    wire bus_quiet = !rx_busy && !tx_pending;

    // Write side of the bus slave.
    wire write_fire = aw_held && w_held && !s_axi_bvalid;
    wire low_lane = w_strb[0];
    wire hit_mode = (aw_addr == can_mode_pkg::OFS_MODE_CONTROL);
    wire hit_timing = (aw_addr == can_mode_pkg::OFS_BIT_TIMING_FIRST);
    wire hit_request = (aw_addr == can_mode_pkg::OFS_REQUEST_CONTROL);
    wire hit_status = (aw_addr == can_mode_pkg::OFS_ENGINE_STATUS);
    wire write_mapped = hit_mode || hit_timing || hit_request || hit_status;
    wire write_mode = write_fire && low_lane && hit_mode && init_active;
    wire write_timing = write_fire && low_lane && hit_timing && init_active;
    wire write_request = write_fire && low_lane && hit_request;
    wire enable_may_change = special_mode || !enable_written;
    wire [7:0] wbyte = w_data[7:0];

    // Requests: init cannot be withdrawn before its acknowledge, sleep is dropped by a wake while asleep.
    wire init_req_written = write_request ? wbyte[can_mode_pkg::BIT_INIT_REQUEST] : init_request;
    wire next_init_request = (init_request && !init_acknowledge) ? 1'b1 : init_req_written;
    wire sleep_req_written = write_request ? wbyte[can_mode_pkg::BIT_SLEEP_REQUEST] : sleep_request;
    wire sleep_wake_clear = sleep_acknowledge && wake_on_traffic_enable && wake;
    wire next_sleep_request = sleep_req_written && !sleep_wake_clear;

    // Mode register image: acknowledge positions never take written data.
    wire [7:0] mode_written = {
        enable_may_change ? wbyte[can_mode_pkg::BIT_MODULE_ENABLE] : mode_reg[can_mode_pkg::BIT_MODULE_ENABLE],
        wbyte[can_mode_pkg::BIT_CLOCK_SELECT:can_mode_pkg::BIT_WAKE_FILTER],
        2'b00
    };
    wire [7:0] next_mode = write_mode ? mode_written : mode_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= can_mode_pkg::READ_ZERO;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= can_mode_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (write_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (write_fire) begin
                w_held <= 1'b0;
            end
            if (write_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= write_mapped ? can_mode_pkg::RESP_OKAY : can_mode_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    // Control registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= can_mode_pkg::RST_MODE_CONTROL;
            timing_reg <= can_mode_pkg::RST_BIT_TIMING;
            init_request <= can_mode_pkg::RST_REQUEST[can_mode_pkg::BIT_INIT_REQUEST];
            sleep_request <= can_mode_pkg::RST_REQUEST[can_mode_pkg::BIT_SLEEP_REQUEST];
            wake_on_traffic_enable <= can_mode_pkg::RST_REQUEST[can_mode_pkg::BIT_WAKE_ENABLE];
            enable_written <= 1'b0;
        end else begin
            mode_reg <= next_mode;
            if (write_timing) begin
                timing_reg <= wbyte;
            end
            init_request <= next_init_request;
            sleep_request <= next_sleep_request;
            if (write_request) begin
                wake_on_traffic_enable <= wbyte[can_mode_pkg::BIT_WAKE_ENABLE];
            end
            if (write_mode) begin
                enable_written <= 1'b1;
            end
        end
    end

    // Handshake state machine; init request outranks sleep.
    always_comb begin
        next_state = state;
        case (state)
            can_mode_pkg::ST_RUN: begin
                if (init_request) begin
                    next_state = can_mode_pkg::ST_ABORT;
                end else if (sleep_request && bus_quiet) begin
                    next_state = can_mode_pkg::ST_SLEEP;
                end
            end
            can_mode_pkg::ST_ABORT: begin
                next_state = can_mode_pkg::ST_INIT;
            end
            can_mode_pkg::ST_INIT: begin
                if (!init_request) begin
                    next_state = can_mode_pkg::ST_RUN;
                end
            end
            can_mode_pkg::ST_SLEEP: begin
                if (init_request) begin
                    next_state = can_mode_pkg::ST_ABORT;
                end else if (!sleep_request || sleep_wake_clear) begin
                    next_state = can_mode_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = can_mode_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= can_mode_pkg::ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Resynchronisation after init: count recessive bits at the engine's bit strobe.
    wire bit_recessive = (engine_rx == can_mode_pkg::RECESSIVE);
    wire run_done = (idle_run == 4'(can_mode_pkg::IDLE_BITS - 1));
    wire runs_done = (busoff_runs == 8'(can_mode_pkg::BUSOFF_IDLE_RUNS - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn || state != can_mode_pkg::ST_RUN) begin
            idle_run <= '0;
            busoff_runs <= '0;
            bus_synced <= 1'b0;
        end else if (bit_strobe && !bus_synced) begin
            if (!bit_recessive) begin
                idle_run <= '0;
            end else if (!run_done) begin
                idle_run <= idle_run + 1'b1;
            end else begin
                idle_run <= '0;
                if (!busoff || runs_done) begin
                    bus_synced <= 1'b1;
                end else begin
                    busoff_runs <= busoff_runs + 1'b1;
                end
            end
        end
    end

    // Register read side.
    wire hit_rd_mode = (s_axi_araddr == can_mode_pkg::OFS_MODE_CONTROL);
    wire hit_rd_timing = (s_axi_araddr == can_mode_pkg::OFS_BIT_TIMING_FIRST);
    wire hit_rd_request = (s_axi_araddr == can_mode_pkg::OFS_REQUEST_CONTROL);
    wire hit_rd_status = (s_axi_araddr == can_mode_pkg::OFS_ENGINE_STATUS);
    wire [7:0] mode_view = {mode_reg[7:2], sleep_acknowledge, init_acknowledge};
    wire [7:0] request_view = {5'b00000, wake_on_traffic_enable, sleep_request, init_request};
    wire [7:0] status_view = {4'b0000, busoff, bus_synced, state};
    wire [7:0] read_byte = hit_rd_mode ? mode_view :
                           hit_rd_timing ? timing_reg :
                           hit_rd_request ? request_view :
                           hit_rd_status ? status_view : 8'h00;
    wire read_mapped = hit_rd_mode || hit_rd_timing || hit_rd_request || hit_rd_status;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= can_mode_pkg::READ_ZERO;
            s_axi_rresp <= can_mode_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, read_byte};
            s_axi_rresp <= read_mapped ? can_mode_pkg::RESP_OKAY : can_mode_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    // Engine controls.
    wire monitor = mode_reg[can_mode_pkg::BIT_MONITOR_MODE];
    wire selftest = mode_reg[can_mode_pkg::BIT_SELFTEST_RETURN];
    assign module_enable = mode_reg[can_mode_pkg::BIT_MODULE_ENABLE];
    assign engine_clock_select = mode_reg[can_mode_pkg::BIT_CLOCK_SELECT];
    assign busoff_recovery_policy = mode_reg[can_mode_pkg::BIT_BUSOFF_POLICY];
    assign ack_error_allow = module_enable && !monitor;
    assign error_count_hold = monitor || !module_enable;
    assign tx_start_allow = module_enable && !monitor && bus_synced;
    assign abort_traffic = (state == can_mode_pkg::ST_ABORT) || init_request;
    assign jump_width_tq = {1'b0, timing_reg[can_mode_pkg::JUMP_MSB:can_mode_pkg::JUMP_LSB]} + 3'd1;
    // The pin falls recessive during init and self-test so a half-sent frame cannot upset the bus.
    assign engine_rx = selftest ? engine_tx : bus_rx;
    assign bus_tx = (selftest || init_request || !module_enable) ? can_mode_pkg::RECESSIVE : engine_tx;

    quantum_divider #(
        .PRESCALE_W(6)
    ) u_divider (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(module_enable && !init_active),
        .prescale_field(timing_reg[can_mode_pkg::PRESCALE_MSB:can_mode_pkg::PRESCALE_LSB]),
        .tq_tick(tq_tick)
    );

    wake_detector #(
        .PULSE_CYCLES(WAKE_CYCLES)
    ) u_wake (
        .aclk(aclk),
        .aresetn(aresetn),
        .armed(sleep_acknowledge && wake_on_traffic_enable),
        .filter_on(mode_reg[can_mode_pkg::BIT_WAKE_FILTER]),
        .bus_level(bus_rx),
        .wake(wake)
    );

    a_mode_locked: assert property (@(posedge aclk) disable iff (!aresetn)
        !init_active |=> $stable(mode_reg))
        else $error("mode control changed outside init mode");
    a_timing_locked: assert property (@(posedge aclk) disable iff (!aresetn)
        !init_active |=> $stable(timing_reg))
        else $error("bit timing changed outside init mode");
    a_enable_once: assert property (@(posedge aclk) disable iff (!aresetn)
        (enable_written && !special_mode) |=> $stable(module_enable))
        else $error("module enable written twice in normal mode");
    a_abort_before_ack: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(init_acknowledge) |-> $past(state) == can_mode_pkg::ST_ABORT && !bus_synced)
        else $error("init acknowledge rose without an abort cycle");
    a_sleep_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(sleep_acknowledge) |-> $past(bus_quiet) && $past(sleep_request))
        else $error("sleep entered while bus busy");
    a_sleep_release: assert property (@(posedge aclk) disable iff (!aresetn)
        (sleep_acknowledge && !sleep_request && !init_request) |=> !sleep_acknowledge)
        else $error("sleep acknowledge kept after request cleared");
    a_wake_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        (sleep_wake_clear && !init_request) |=> !sleep_acknowledge && !sleep_request)
        else $error("wake did not leave sleep");
    a_monitor_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        monitor |-> !ack_error_allow && error_count_hold && !tx_start_allow)
        else $error("monitor mode let the node drive the bus");
    a_loop_return: assert property (@(posedge aclk) disable iff (!aresetn)
        selftest |-> engine_rx == engine_tx && bus_tx == can_mode_pkg::RECESSIVE)
        else $error("self-test return not internal");
    a_sync_needs_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(bus_synced) |-> $past(run_done) && $past(bit_strobe))
        else $error("bus sync without eleven recessive bits");
endmodule // can_mode_control

// *** verification/can_bus_node.sv ***
// Far side of the CAN bus: the other nodes, seen through the transceiver as one wired-AND line.
// Assumes levels synchronous to aclk; the line rests recessive between frames.
`timescale 1ns/1ps
module can_bus_node (
    // Clock
    input wire logic aclk,
    // Bench command
    input wire logic [7:0] dominant_len,
    input wire logic start,
    // Line
    input wire logic bus_tx,
    output logic bus_rx
);
    int left = 0;
    always @(posedge aclk) begin
        if (start) left <= dominant_len;
        else if (left > 0) left <= left - 1;
    end
    // Any node driving dominant pulls the line low; otherwise the bus bias keeps it recessive.
    assign bus_rx = bus_tx & (left == 0);
endmodule // can_bus_node

// *** verification/can_mode_control_tb_top.sv ***
// Self-checking bench for the CAN mode block: AXI4-Lite master tasks, a register model, port checks.
// Assumes the bus node model on the far side and a 40 MHz aclk.
`timescale 1ns/1ps
module can_mode_control_tb_top;
    logic aclk = 0, aresetn = 0, special_mode = 0, rx_busy = 0, bit_strobe = 0, go = 0;
    logic engine_tx = 1, tx_pending = 0, busoff = 0, engine_rx, abort_traffic, bus_synced, tx_start_allow;
    logic [7:0] dlen = 8'h03;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, mode, tim, v;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_rx, bus_tx, tq_tick;
    logic module_enable, engine_clock_select, busoff_recovery_policy, ack_error_allow, error_count_hold;
    logic [1:0] s_axi_bresp, s_axi_rresp, br;
    logic [2:0] jump_width_tq;
    int n_fail = 0, checks_done = 0, cyc = 0, ticks;
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) bit_strobe <= ($urandom_range(3, 0) == 0);
    can_mode_control #(.WAKE_CYCLES(4)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .special_mode, .bit_strobe, .engine_tx, .rx_busy, .tx_pending, .busoff, .engine_rx,
        .abort_traffic, .bus_synced, .tq_tick, .jump_width_tq, .module_enable, .engine_clock_select,
        .busoff_recovery_policy, .ack_error_allow, .error_count_hold, .tx_start_allow, .bus_rx, .bus_tx);
    can_bus_node NODE (.aclk, .dominant_len(dlen), .start(go), .bus_tx, .bus_rx);
    task automatic summarize();
        if (n_fail == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= {3'($urandom), 1'b1};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = can_mode_pkg::RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rdata", {24'h00_0000, e}, s_axi_rdata);
        chk("rresp", r, s_axi_rresp);
    endtask
    // The other nodes hold the line dominant for n cycles; returns once the line is recessive again.
    task automatic pulse(input logic [7:0] n);
        dlen <= n;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        repeat (int'(n) + 1) @(posedge aclk);
    endtask
    // A hang anywhere ends the run through the same report.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        v = 8'($urandom(32'h0000_54df));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("start", 5'h07, {bus_synced, tx_start_allow, abort_traffic, bus_tx, engine_rx});
        rc(8'h00, 8'h01);
        rc(8'h04, 8'h00);
        rc(8'h08, 8'h01);
        rc(8'h10, 8'h00, can_mode_pkg::RESP_SLVERR);
        wr(8'h10, 8'hff);
        chk("bresp", can_mode_pkg::RESP_SLVERR, br);
        // The last pass tries to clear the enable, which must stick outside special operation.
        for (int i = 0; i < 3; i++) begin
            v = {i != 2, 1'($urandom), !i[0], i[0], 1'($urandom), 3'b011};
            wr(8'h00, v);
            mode = {1'b1, v[6:2], 2'b01};
            rc(8'h00, mode);
            chk("pins", {mode[7], mode[6], mode[3]}, {module_enable, engine_clock_select, busoff_recovery_policy});
            chk("listen", {!mode[4], mode[4]}, {ack_error_allow, error_count_hold});
        end
        // Special operation lets the enable be cleared and set again.
        special_mode <= 1'b1;
        wr(8'h00, mode & 8'h7f);
        rc(8'h00, mode & 8'h7f);
        chk("enable", 0, module_enable);
        wr(8'h00, mode);
        special_mode <= 1'b0;
        rc(8'h00, mode);
        tim = 8'($urandom);
        wr(8'h04, tim);
        rc(8'h04, tim);
        chk("jump", tim[7:6] + 3'd1, jump_width_tq);
        wr(8'h08, 8'h00);
        mode[0] = 1'b0;
        rc(8'h00, mode);
        wr(8'h00, ~mode);
        wr(8'h04, ~tim);
        rc(8'h00, mode);
        rc(8'h04, tim);
        ticks = 0;
        repeat (20 * (int'(tim[5:0]) + 1)) begin
            @(posedge aclk);
            ticks += int'(tq_tick);
        end
        chk("ticks", 20, ticks);
        repeat (300) @(posedge aclk);
        chk("sync", 2'b11, {bus_synced, tx_start_allow});
        engine_tx <= 1'b0;
        @(posedge aclk);
        chk("loop", {mode[5], 1'b0}, {bus_tx, engine_rx});
        engine_tx <= 1'b1;
        rx_busy <= 1'b1;
        tx_pending <= 1'b1;
        wr(8'h08, 8'h06);
        rc(8'h00, mode);
        rx_busy <= 1'b0;
        rc(8'h00, mode);
        tx_pending <= 1'b0;
        rc(8'h00, mode | 8'h02);
        chk("asleep", 0, bus_synced);
        pulse(8'h03);
        rc(8'h08, 8'h04);
        rc(8'h00, mode);
        wr(8'h08, 8'h06);
        rc(8'h00, mode | 8'h02);
        wr(8'h08, 8'h04);
        rc(8'h00, mode);
        // Back through init to turn the wake filter on: a short pulse must not wake, a long one must.
        wr(8'h08, 8'h01);
        mode[2] = 1'b1;
        wr(8'h00, mode);
        wr(8'h08, 8'h06);
        pulse(8'h03);
        rc(8'h00, mode | 8'h02);
        busoff <= 1'b1;
        pulse(8'h08);
        rc(8'h08, 8'h04);
        rc(8'h00, mode);
        // Bus-off needs 128 runs of 11 recessive strobes, far more than 300 cycles can hold.
        repeat (300) @(posedge aclk);
        chk("busoff_early", 0, bus_synced);
        repeat (8000) @(posedge aclk);
        chk("busoff_sync", 1, bus_synced);
        summarize();
    end
endmodule // can_mode_control_tb_top
